// file: rtl/rtcfc_century_cnt.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtcfc_params.svh"
module rtcfc_century_cnt
    import rtcfc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    rtcfc_cnt_if.cnt bus
);
    rtcfc_digit_t units_q;
    rtcfc_digit_t tens_q;

    // load wins over a simultaneous increment; 99 wraps to 00
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            units_q <= 4'(`RTCFC_RST_CENTURY & 8'h0f);
            tens_q <= 4'(`RTCFC_RST_CENTURY >> 4);
        end
        else if (bus.load)
        begin
            units_q <= bus.load_val[3:0];
            tens_q <= bus.load_val[7:4];
        end
        else if (bus.inc)
        begin
            if (units_q >= `RTCFC_BCD_MAX)
            begin
                units_q <= 4'h0;
                tens_q <= (tens_q >= `RTCFC_BCD_MAX) ? 4'h0 : tens_q + 4'h1;
            end
            else
            begin
                units_q <= units_q + 4'h1;
            end
        end
    end

    assign bus.count = {tens_q, units_q};
endmodule : rtcfc_century_cnt
`default_nettype wire

// file: rtl/rtcfc_cnt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rtcfc_cnt_if;
    import rtcfc_pkg::*;
    logic inc;
    logic load;
    rtcfc_byte_t load_val;
    rtcfc_byte_t count;
    modport ctrl (output inc, output load, output load_val, input count);
    modport cnt (input inc, input load, input load_val, output count);
endinterface : rtcfc_cnt_if
`default_nettype wire

// file: rtl/rtcfc_params.svh
`ifndef RTCFC_PARAMS_SVH
`define RTCFC_PARAMS_SVH
`define RTCFC_ADDR_FLAGS 8'h00
`define RTCFC_ADDR_CENTURY 8'h01
`define RTCFC_BIT_WDF 7
`define RTCFC_BIT_AF 6
`define RTCFC_BIT_PF 5
`define RTCFC_BIT_OSCILLATOR_FAIL_FLAG 4
`define RTCFC_BIT_BPF 3
`define RTCFC_BIT_CAL 2
`define RTCFC_BIT_W 1
`define RTCFC_BIT_R 0
`define RTCFC_RST_CENTURY 8'h00
`define RTCFC_RST_FLAG 1'h0
`define RTCFC_BCD_MAX 4'h9
`define RTCFC_SYNC_STAGES 2
`endif

// file: rtl/rtcfc_pkg.sv
package rtcfc_pkg;
    typedef logic [7:0] rtcfc_byte_t;
    typedef logic [3:0] rtcfc_digit_t;
endpackage : rtcfc_pkg

// file: rtl/rtcfc_regs.sv
// Summary of operation
// [RULE_01] The century count holds two decimal digits, tens high and units low, each 0 to 9.
// [RULE_02] The watchdog flag in bit 7 sets when the watchdog reaches zero and clears on a read.
// [RULE_03] The alarm flag sets on an alarm match and clears on a read of the flag register.
// [RULE_04] The read-only power fail flag sets below the fail threshold and clears on a read.
// [RULE_05] The oscillator fail flag sets when the oscillator stops and only software clears it.
// [RULE_06] The backup supply flag sets when the backup supply falls below its minimum level.
// [RULE_07] With the calibration bit set the square wave pin carries the calibration wave.
// [RULE_08] Write bit set lets software update registers; clearing it loads the counters.
// [RULE_09] Read bit set freezes the visible registers; clearing it resumes their updates.
// [RULE_10] The host clears the read bit after a time read and the write bit after a write.
// [RULE_11] The running counters keep advancing while the visible registers are frozen.
`timescale 1ns/10ps
`default_nettype none
`include "rtcfc_params.svh"
module rtcfc_regs
    import rtcfc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic watchdog_zero,
    input wire logic alarm_match,
    input wire logic century_tick,
    input wire logic power_low_pin,
    input wire logic backup_low_pin,
    input wire logic osc_stopped_pin,
    input wire logic oscillator_fail_flag_saved_pin,
    input wire logic cal_wave,
    input wire logic freq_wave,
    output logic square_wave_out,
    output logic oscillator_fail_flag,
    output logic timekeeping_write_enable,
    output logic counter_load
);
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic power_low;
    logic backup_low;
    logic osc_stopped;
    logic oscillator_fail_flag_saved;
    logic watchdog_expired_flag;
    logic alarm_match_flag;
    logic main_power_fail_flag;
    logic backup_supply_fail_flag;
    logic cal_q;
    logic w_q;
    logic r_q;
    logic w_prev_q;
    logic load;
    logic wr_flags;
    logic wr_cent;
    logic rd_flags;
    rtcfc_byte_t shadow_q;
    rtcfc_byte_t flags;
    rtcfc_byte_t wr_bcd;
    rtcfc_cnt_if cnt_bus ();

    assign pin_raw = {oscillator_fail_flag_saved_pin, osc_stopped_pin, backup_low_pin, power_low_pin};

    // two-stage synchronisers for the supply and oscillator monitors and saved flag
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            // no reset: the saved oscillator flag must reach its flop while reset is held
            always_ff @(posedge core_clk)
            begin
                sync1_q[gi] <= pin_raw[gi];
                sync2_q[gi] <= sync1_q[gi];
            end
        end
    endgenerate

    assign power_low = sync2_q[0];
    assign backup_low = sync2_q[1];
    assign osc_stopped = sync2_q[2];
    assign oscillator_fail_flag_saved = sync2_q[3];

    assign wr_flags = reg_wr && (reg_addr == `RTCFC_ADDR_FLAGS);
    assign wr_cent = reg_wr && (reg_addr == `RTCFC_ADDR_CENTURY);
    assign rd_flags = reg_rd && (reg_addr == `RTCFC_ADDR_FLAGS);

    // read-to-clear flags; a set in the same cycle wins
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            watchdog_expired_flag <= `RTCFC_RST_FLAG;
            alarm_match_flag <= `RTCFC_RST_FLAG;
            main_power_fail_flag <= `RTCFC_RST_FLAG;
        end
        else
        begin
            watchdog_expired_flag <= watchdog_zero | (watchdog_expired_flag & ~rd_flags); // RULE_02
            alarm_match_flag <= alarm_match | (alarm_match_flag & ~rd_flags); // RULE_03
            main_power_fail_flag <= power_low | (main_power_fail_flag & ~rd_flags); // RULE_04
        end
    end

    // oscillator fail survives reset through its saved copy
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            oscillator_fail_flag <= oscillator_fail_flag_saved;
        end
        else if (osc_stopped) // RULE_05
        begin
            oscillator_fail_flag <= 1'b1;
        end
        else if (wr_flags && w_q && !reg_wdata[`RTCFC_BIT_OSCILLATOR_FAIL_FLAG]) // RULE_05
        begin
            oscillator_fail_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            backup_supply_fail_flag <= `RTCFC_RST_FLAG;
        end
        else if (backup_low) // RULE_06
        begin
            backup_supply_fail_flag <= 1'b1;
        end
        else if (wr_flags && w_q && !reg_wdata[`RTCFC_BIT_BPF])
        begin
            backup_supply_fail_flag <= 1'b0;
        end
    end

    // control bits are always writable
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            cal_q <= `RTCFC_RST_FLAG;
            w_q <= `RTCFC_RST_FLAG;
            r_q <= `RTCFC_RST_FLAG;
            w_prev_q <= `RTCFC_RST_FLAG;
        end
        else
        begin
            if (wr_flags)
            begin
                cal_q <= reg_wdata[`RTCFC_BIT_CAL];
                w_q <= reg_wdata[`RTCFC_BIT_W];
                r_q <= reg_wdata[`RTCFC_BIT_R];
            end
            w_prev_q <= w_q;
        end
    end

    assign load = w_prev_q && !w_q; // RULE_08
    assign counter_load = load;
    assign timekeeping_write_enable = w_q; // RULE_08

    // digits above 9 saturate at 9
    assign wr_bcd[7:4] = (reg_wdata[7:4] > `RTCFC_BCD_MAX) ? `RTCFC_BCD_MAX : reg_wdata[7:4]; // RULE_01
    assign wr_bcd[3:0] = (reg_wdata[3:0] > `RTCFC_BCD_MAX) ? `RTCFC_BCD_MAX : reg_wdata[3:0]; // RULE_01

    // visible century: written under W, frozen under R, else tracks counter
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            shadow_q <= `RTCFC_RST_CENTURY;
        end
        else if (w_q)
        begin
            if (wr_cent) // RULE_08
            begin
                shadow_q <= wr_bcd;
            end
        end
        else if (!r_q && !load) // RULE_09
        begin
            shadow_q <= cnt_bus.count;
        end
    end

    assign cnt_bus.inc = century_tick; // RULE_11
    assign cnt_bus.load = load;
    assign cnt_bus.load_val = shadow_q;

    rtcfc_century_cnt u_cnt (
        .core_clk(core_clk),
        .resetn(resetn),
        .bus(cnt_bus)
    );

    assign flags = {watchdog_expired_flag, alarm_match_flag, main_power_fail_flag,
                    oscillator_fail_flag, backup_supply_fail_flag, cal_q, w_q, r_q};

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (reg_addr == `RTCFC_ADDR_FLAGS)
            begin
                reg_rdata <= flags;
            end
            else if (reg_addr == `RTCFC_ADDR_CENTURY)
            begin
                reg_rdata <= shadow_q;
            end
            else
            begin
                reg_rdata <= 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            square_wave_out <= 1'b0;
        end
        else
        begin
            square_wave_out <= cal_q ? cal_wave : freq_wave; // RULE_07
        end
    end

    sequence w_fall_s;
        $fell(w_q);
    endsequence

    sequence loaded_s;
        ##1 (cnt_bus.count == $past(shadow_q));
    endsequence

    bcd_range_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_01
        (cnt_bus.count[3:0] <= 4'h9) && (cnt_bus.count[7:4] <= 4'h9))
        else $error("century digit out of range");
    wdf_set_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_02
        watchdog_zero ##1 rd_flags |-> ##1 reg_rdata[7])
        else $error("watchdog flag not reported");
    wdf_clear_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_02
        rd_flags && !watchdog_zero |=> !watchdog_expired_flag)
        else $error("watchdog flag not cleared by read");
    alarm_flag_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_03
        alarm_match |=> alarm_match_flag)
        else $error("alarm flag not set");
    power_flag_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_04
        $rose(power_low) |=> main_power_fail_flag)
        else $error("power fail flag not set");
    oscillator_fail_flag_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_05
        $fell(oscillator_fail_flag) |-> $past(wr_flags && w_q && !reg_wdata[`RTCFC_BIT_OSCILLATOR_FAIL_FLAG]))
        else $error("oscillator flag dropped without software");
    bpf_set_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_06
        backup_low |=> backup_supply_fail_flag)
        else $error("backup flag not set");
    cal_route_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_07
        cal_q |=> square_wave_out == $past(cal_wave))
        else $error("square wave not calibration");
    load_xfer_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_08
        w_fall_s |-> loaded_s)
        else $error("counter not loaded after write bit cleared");
    freeze_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_09
        r_q && !w_q |=> $stable(shadow_q))
        else $error("visible century changed while frozen");
    run_on_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_11
        r_q && century_tick && !load && (cnt_bus.count[3:0] < 4'h9)
        |=> cnt_bus.count == $past(cnt_bus.count) + 8'h01)
        else $error("counter stopped during freeze");
endmodule : rtcfc_regs
`default_nettype wire

// file: verif/rtcfc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module rtcfc_host_model
    import rtcfc_pkg::*;
(
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // one-cycle write strobe, address and data held with it
    task automatic write_reg(input rtcfc_byte_t addr, input rtcfc_byte_t data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : write_reg

    // read data is registered at the taking edge and holds until the next read
    task automatic read_reg(input rtcfc_byte_t addr, output rtcfc_byte_t data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask : read_reg
endmodule : rtcfc_host_model
`default_nettype wire

// file: verif/rtcfc_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rtcfc_regs_tb
    import rtcfc_pkg::*;
;
    logic core_clk, resetn;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, watchdog_zero, alarm_match, century_tick;
    logic power_low_pin, backup_low_pin, osc_stopped_pin, oscillator_fail_flag_saved_pin;
    logic cal_wave, freq_wave, square_wave_out, oscillator_fail_flag;
    logic timekeeping_write_enable, counter_load;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int load_pulses = 0;
    rtcfc_byte_t rd;

    rtcfc_regs rtcfc_regs_i (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .watchdog_zero(watchdog_zero), .alarm_match(alarm_match),
        .century_tick(century_tick), .power_low_pin(power_low_pin),
        .backup_low_pin(backup_low_pin), .osc_stopped_pin(osc_stopped_pin),
        .oscillator_fail_flag_saved_pin(oscillator_fail_flag_saved_pin), .cal_wave(cal_wave), .freq_wave(freq_wave),
        .square_wave_out(square_wave_out), .oscillator_fail_flag(oscillator_fail_flag),
        .timekeeping_write_enable(timekeeping_write_enable), .counter_load(counter_load));

    rtcfc_host_model rtcfc_host_model_i (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        if (counter_load === 1'b1)
            load_pulses++;
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input rtcfc_byte_t exp, input rtcfc_byte_t got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rd_chk(input string what, input rtcfc_byte_t addr, input rtcfc_byte_t exp);
        rtcfc_host_model_i.read_reg(addr, rd);
        chk(what, exp, rd);
    endtask : rd_chk

    // one-cycle pulse on an event input: 0 tick, 1 watchdog, 2 alarm
    task automatic pulse(input int which);
        @(posedge core_clk);
        case (which)
            0: century_tick <= 1'b1;
            1: watchdog_zero <= 1'b1;
            default: alarm_match <= 1'b1;
        endcase
        @(posedge core_clk);
        {watchdog_zero, alarm_match, century_tick} <= 3'h0;
    endtask : pulse

    // write a century value through the write-enable window and let it load
    task automatic load_century(input rtcfc_byte_t val);
        rtcfc_host_model_i.write_reg(8'h00, 8'h02);
        rtcfc_host_model_i.write_reg(8'h01, val);
        rtcfc_host_model_i.write_reg(8'h00, 8'h00);
        repeat (4) @(posedge core_clk);
    endtask : load_century

    initial
    begin
        resetn = 1'b0;
        {watchdog_zero, alarm_match, century_tick, power_low_pin} = 4'h0;
        {backup_low_pin, osc_stopped_pin, oscillator_fail_flag_saved_pin, cal_wave, freq_wave} = 5'h00;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        rd_chk("century after reset", 8'h01, 8'h00);
        rd_chk("flags after reset", 8'h00, 8'h00);
        rd_chk("unmapped read", 8'h07, 8'h00);
        load_century(8'h21);
        rd_chk("century loaded", 8'h01, 8'h21);
        chk("load pulses", 8'h01, 8'(load_pulses));
        rtcfc_host_model_i.write_reg(8'h00, 8'h01);
        pulse(0);
        pulse(0);
        rd_chk("century frozen", 8'h01, 8'h21);
        rtcfc_host_model_i.write_reg(8'h00, 8'h00);
        repeat (4) @(posedge core_clk);
        rd_chk("century resumed", 8'h01, 8'h23);
        load_century(8'hab);
        rd_chk("century saturated", 8'h01, 8'h99);
        rtcfc_host_model_i.write_reg(8'h01, 8'h55);
        repeat (4) @(posedge core_clk);
        rd_chk("century write locked", 8'h01, 8'h99);
        pulse(0);
        repeat (3) @(posedge core_clk);
        rd_chk("century wrap", 8'h01, 8'h00);
        pulse(1);
        pulse(2);
        @(posedge core_clk);
        {power_low_pin, backup_low_pin, osc_stopped_pin} <= 3'h7;
        repeat (3) @(posedge core_clk);
        {power_low_pin, backup_low_pin, osc_stopped_pin} <= 3'h0;
        repeat (5) @(posedge core_clk);
        chk("osc flag out", 8'h01, {7'h00, oscillator_fail_flag});
        rd_chk("flags all set", 8'h00, 8'hf8);
        rd_chk("flags after read", 8'h00, 8'h18);
        rtcfc_host_model_i.write_reg(8'h00, 8'h00);
        rd_chk("sticky flags", 8'h00, 8'h18);
        rtcfc_host_model_i.write_reg(8'h00, 8'h02);
        rtcfc_host_model_i.write_reg(8'h00, 8'h02);
        rd_chk("flags cleared", 8'h00, 8'h02);
        chk("write enable out", 8'h01, {7'h00, timekeeping_write_enable});
        rtcfc_host_model_i.write_reg(8'h00, 8'h00);
        cal_wave <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("freq wave out", 8'h00, {7'h00, square_wave_out});
        rtcfc_host_model_i.write_reg(8'h00, 8'h04);
        repeat (3) @(posedge core_clk);
        chk("cal wave out", 8'h01, {7'h00, square_wave_out});
        freq_wave <= 1'b1;
        cal_wave <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("cal overrides", 8'h00, {7'h00, square_wave_out});
        oscillator_fail_flag_saved_pin <= 1'b1;
        resetn <= 1'b0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        rd_chk("flags after second reset", 8'h00, 8'h10);
        complete_run();
    end
endmodule : rtcfc_regs_tb
`default_nettype wire
